/* hdl/l2ap_pkg.sv */
package l2ap_pkg;

    // ****************************************
    // widths and bit positions
    // ****************************************
    localparam int ADDR_W       = 32;
    localparam int PAR_W        = 4;
    localparam int PROC_N       = 4;
    localparam int BYTE_W       = 8;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

    // ****************************************
    // tenure states
    // ****************************************
    typedef enum logic [2:0] {
        L2AP_IDLE = 3'h1,
        L2AP_WAIT = 3'h2,
        L2AP_TEN  = 3'h4
    } l2ap_ten_type;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [PROC_N-1:0] grant_n;
        logic [PROC_N-1:0] request_n;
        logic [PROC_N-1:0] data_grant_n;
    } l2ap_arb_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [PAR_W-1:0]  par;
    } l2ap_abus_type;

endpackage

/* hdl/l2ap_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module l2ap_sync
    import l2ap_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    // ****************************************
    // two-stage synchroniser
    // ****************************************
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_q;
    logic [W-1:0] s2_d;

    always_comb begin
        s1_d = din;
        s2_d = s1_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= '1;
            s2_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign dout = s2_q;

endmodule
`default_nettype wire

/* hdl/l2ap_port.sv */
// Summary of operation
// - address lines input, driven during own tenure
// - busy qualifies grant; driven during own tenure
// - parity error low three cycles after start
// - parity checked only when enable pin low
// - retry asserted on snoop hit dirty line
// - effective grant is OR of four
// - effective request is OR of four
// - effective data grant is OR of four
`timescale 1ns/100ps
`default_nettype none
module l2ap_port
    import l2ap_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire l2ap_abus_type     abus_in,
    output l2ap_abus_type          abus_out,
    output logic                   abus_oe_n,
    input  wire logic              transfer_start_n,
    input  wire logic              parity_enable_pin_n,
    output logic                   parity_error_out,
    output logic                   parity_error_oe_n,
    input  wire logic              address_tenure_busy_in_n,
    output logic                   address_tenure_busy_out,
    output logic                   address_tenure_busy_oe_n,
    input  wire logic              address_acknowledge_in_n,
    input  wire logic              address_retry_in_n,
    output logic                   address_retry_out,
    output logic                   address_retry_oe_n,
    input  wire l2ap_arb_type      arb_in,
    output logic                   eff_grant_n,
    output logic                   eff_request_n,
    output logic                   eff_data_grant_n,
    output logic                   retry_seen,
    input  wire logic              tenure_req,
    input  wire logic [ADDR_W-1:0] tenure_addr,
    output logic                   tenure_busy,
    output logic                   tenure_done,
    input  wire logic              snoop_dirty_hit,
    output logic [ADDR_W-1:0]      snoop_addr
);

    // ****************************************
    // input synchronisation
    // ****************************************
    localparam int SW = ADDR_W + PAR_W + 5 + 3 * PROC_N;
    logic [SW-1:0]  sync_in;
    logic [SW-1:0]  sync_out;
    l2ap_abus_type  ab_s;
    l2ap_arb_type   arb_s;
    logic           ts_s;
    logic           pen_s;
    logic           abb_s;
    logic           address_acknowledge_s;
    logic           address_retry_s;

    assign sync_in = {abus_in, arb_in, transfer_start_n, parity_enable_pin_n,
                      address_tenure_busy_in_n, address_acknowledge_in_n,
                      address_retry_in_n};

    l2ap_sync #(.W(SW)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (sync_in),
        .dout  (sync_out)
    );

    assign {ab_s, arb_s, ts_s, pen_s, abb_s, address_acknowledge_s, address_retry_s} = sync_out;

    // ****************************************
    // grant, request, data grant merging
    // ****************************************
    logic grant_n;
    assign grant_n          = &arb_s.grant_n;
    assign eff_grant_n      = grant_n;
    assign eff_request_n    = &arb_s.request_n;
    assign eff_data_grant_n = &arb_s.data_grant_n;

    // ****************************************
    // parity check and error pulse
    // ****************************************
    logic [PAR_W-1:0] byte_ok;
    logic             par_err;
    logic             ape_q;
    logic             ape_d;
    logic [ADDR_W-1:0] snp_q;
    logic [ADDR_W-1:0] snp_d;

    // bit 0 is the most significant address line
    always_comb begin
        for (int i = 0; i < PAR_W; i++) begin
            byte_ok[i] = ^{ab_s.addr[ADDR_W-1-i*BYTE_W -: BYTE_W], ab_s.par[PAR_W-1-i]};
        end
    end

    assign par_err = !ts_s && !pen_s && (byte_ok != '1);

    always_comb begin
        ape_d = par_err;
        snp_d = ts_s ? snp_q : ab_s.addr;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ape_q <= 1'b0;
            snp_q <= ADDR_RST;
        end else begin
            ape_q <= ape_d;
            snp_q <= snp_d;
        end
    end

    assign parity_error_out  = 1'b0;
    assign parity_error_oe_n = !ape_q;
    assign snoop_addr        = snp_q;

    // ****************************************
    // own address tenure
    // ****************************************
    l2ap_ten_type      st_q;
    l2ap_ten_type      st_d;
    logic [ADDR_W-1:0] ta_q;
    logic [ADDR_W-1:0] ta_d;
    logic              done_q;
    logic              done_d;

    always_comb begin
        st_d   = st_q;
        ta_d   = ta_q;
        done_d = 1'b0;
        case (st_q)
            L2AP_IDLE: begin
                if (tenure_req) begin
                    ta_d = tenure_addr;
                    st_d = L2AP_WAIT;
                end
            end
            L2AP_WAIT: begin
                if (!grant_n && abb_s) begin
                    st_d = L2AP_TEN;
                end
            end
            L2AP_TEN: begin
                if (!address_acknowledge_s) begin
                    st_d   = L2AP_IDLE;
                    done_d = 1'b1;
                end
            end
            default: st_d = L2AP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q   <= L2AP_IDLE;
            ta_q   <= ADDR_RST;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            ta_q   <= ta_d;
            done_q <= done_d;
        end
    end

    function automatic logic [PAR_W-1:0] odd_par(input logic [ADDR_W-1:0] a);
        logic [PAR_W-1:0] p;
        p = '0;
        for (int i = 0; i < PAR_W; i++) begin
            p[PAR_W-1-i] = ~^a[ADDR_W-1-i*BYTE_W -: BYTE_W];
        end
        return p;
    endfunction

    assign address_tenure_busy_out  = 1'b0;
    assign address_tenure_busy_oe_n = (st_q != L2AP_TEN);
    assign abus_out.addr            = ta_q;
    assign abus_out.par             = odd_par(ta_q);
    assign abus_oe_n                = (st_q != L2AP_TEN);
    assign tenure_busy              = (st_q != L2AP_IDLE);
    assign tenure_done              = done_q;

    // ****************************************
    // address retry
    // ****************************************
    logic rty_q;
    logic rty_d;

    always_comb begin
        rty_d = snoop_dirty_hit;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rty_q <= 1'b0;
        end else begin
            rty_q <= rty_d;
        end
    end

    assign address_retry_out  = 1'b0;
    assign address_retry_oe_n = !rty_q;
    assign retry_seen         = !address_retry_s;

endmodule
`default_nettype wire

/* tb/l2ap_props.sv */
`timescale 1ns/100ps
`default_nettype none
module l2ap_props
    import l2ap_pkg::*;
(
    input wire logic          clk,
    input wire logic          rst_n,
    input wire l2ap_abus_type abus_in,
    input wire logic          abus_oe_n,
    input wire logic          transfer_start_n,
    input wire logic          parity_enable_pin_n,
    input wire logic          parity_error_oe_n,
    input wire logic          address_tenure_busy_oe_n,
    input wire logic          address_retry_oe_n,
    input wire l2ap_arb_type  arb_in,
    input wire logic          eff_grant_n,
    input wire logic          eff_request_n,
    input wire logic          eff_data_grant_n,
    input wire logic          snoop_dirty_hit
);
    logic [3:0] ok;
    always_comb begin
        for (int i = 0; i < 4; i++) ok[i] = ^{abus_in.addr[8*i+:8], abus_in.par[i]};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence bad_start;
        !transfer_start_n && !parity_enable_pin_n && ok != 4'hF;
    endsequence
    err_flag_a: assert property (bad_start |-> ##[2:4] !parity_error_oe_n)
        else $error("no parity pulse");
    err_once_a: assert property (!parity_error_oe_n |=> parity_error_oe_n)
        else $error("pulse too long");
    err_gate_a: assert property (parity_enable_pin_n [*5] |-> parity_error_oe_n)
        else $error("error while disabled");
    grant_or_a: assert property (eff_grant_n == &$past(arb_in.grant_n, 2))
        else $error("bad grant");
    req_or_a: assert property (eff_request_n == &$past(arb_in.request_n, 2))
        else $error("bad request");
    dgnt_or_a: assert property (eff_data_grant_n == &$past(arb_in.data_grant_n, 2))
        else $error("bad data grant");
    retry_drv_a: assert property (address_retry_oe_n == !$past(snoop_dirty_hit))
        else $error("bad retry");
    busy_drv_a: assert property (!address_tenure_busy_oe_n |-> !abus_oe_n)
        else $error("busy without address");
endmodule
bind l2ap_port l2ap_props u_props (
    .clk                      (clk),
    .rst_n                    (rst_n),
    .abus_in                  (abus_in),
    .abus_oe_n                (abus_oe_n),
    .transfer_start_n         (transfer_start_n),
    .parity_enable_pin_n      (parity_enable_pin_n),
    .parity_error_oe_n        (parity_error_oe_n),
    .address_tenure_busy_oe_n (address_tenure_busy_oe_n),
    .address_retry_oe_n       (address_retry_oe_n),
    .arb_in                   (arb_in),
    .eff_grant_n              (eff_grant_n),
    .eff_request_n            (eff_request_n),
    .eff_data_grant_n         (eff_data_grant_n),
    .snoop_dirty_hit          (snoop_dirty_hit)
);
`default_nettype wire

/* tb/l2ap_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
module l2ap_bus_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic want,
    input  wire logic busy_oe_n,
    input  wire logic slow,
    output logic      grant_n,
    output logic      ack_n
);
    int wait_q = 0;
    int ten_q = 0;
    always @(posedge clk) begin
        wait_q <= (rst_n && want && busy_oe_n) ? wait_q + 1 : 0;
        ten_q <= (rst_n && !busy_oe_n) ? ten_q + 1 : 0;
    end
    // grant after a delay when slow (at once otherwise), released once the tenure starts
    assign grant_n = !(want && busy_oe_n && wait_q >= (slow ? 5 : 0));
    // acknowledge ends the driven tenure
    assign ack_n = !(!busy_oe_n && ten_q == (slow ? 4 : 0));
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import l2ap_pkg::*;
;
    logic          clk = 0, rst_n = 0, ts_n = 1, pen_n = 1, req = 0, hit = 0, slow = 0;
    logic          mg_n, ack_n, aoe_n, pe_oe_n, bo, bo_oe_n, ro, ro_oe_n, busy, done, rs;
    logic [11:0]   arb_r = 12'hFFF;
    logic [31:0]   t_addr = 32'h0;
    logic [31:0]   snp;
    l2ap_abus_type ext = '0, aout;
    int            miscompares = 0, samples_checked = 0, n, m;
    always #5 clk = ~clk;
    l2ap_port dut (
        .clk, .rst_n, .abus_in(aoe_n ? ext : aout), .abus_out(aout), .abus_oe_n(aoe_n),
        .transfer_start_n(ts_n), .parity_enable_pin_n(pen_n), .parity_error_out(),
        .parity_error_oe_n(pe_oe_n), .address_tenure_busy_in_n(bo_oe_n | bo),
        .address_tenure_busy_out(bo), .address_tenure_busy_oe_n(bo_oe_n),
        .address_acknowledge_in_n(ack_n), .address_retry_in_n(ro_oe_n | ro),
        .address_retry_out(ro), .address_retry_oe_n(ro_oe_n),
        .arb_in({arb_r[11:8] & {3'h7, mg_n}, arb_r[7:0]}), .eff_grant_n(),
        .eff_request_n(), .eff_data_grant_n(), .retry_seen(rs), .tenure_req(req),
        .tenure_addr(t_addr), .tenure_busy(busy), .tenure_done(done),
        .snoop_dirty_hit(hit), .snoop_addr(snp)
    );
    l2ap_bus_model u_bus (
        .clk, .rst_n, .want(busy), .busy_oe_n(bo_oe_n), .slow, .grant_n(mg_n), .ack_n
    );
    task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [3:0] opar(logic [31:0] a);
        for (int i = 0; i < 4; i++) opar[i] = ~^a[8*i+:8];
    endfunction
    initial begin
        void'($urandom(32'h7464));
        repeat (16) @(negedge clk);
        rst_n = 1;
        for (int k = 0; k < 40; k++) begin
            arb_r = 12'($urandom);
            hit = k[2];
            ext.addr = $urandom;
            ext.par = opar(ext.addr) ^ (k[0] ? 4'h1 << k[4:3] : 4'h0);
            pen_n = k[1];
            ts_n = 0;
            @(negedge clk);
            ts_n = 1;
            n = 0;
            repeat (6) begin
                @(negedge clk);
                n += !pe_oe_n;
            end
            chk("parity_error", n, k[1:0] == 2'b01);
            chk("snoop_addr", snp, ext.addr);
            chk("retry_oe_n", ro_oe_n, !k[2]);
            chk("retry_seen", rs, k[2]);
        end
        arb_r = 12'hFFF;
        hit = 0;
        $display("test random done");
        for (int k = 0; k < 4; k++) begin
            slow = k[1];
            t_addr = $urandom;
            req = 1;
            n = 0;
            m = 0;
            do begin
                @(negedge clk);
                req = 0;
                n++;
                if (aoe_n === 1'b0) begin
                    m++;
                    chk("addr", aout.addr, t_addr);
                    chk("addr_par", aout.par, opar(t_addr));
                    chk("busy_oe_n", bo_oe_n, 0);
                end
            end while (done !== 1'b1 && n < 80);
            chk("wait", n < 80, 1);
            chk("driven", m > 0, 1);
            if (n == 80) finish_test();
            @(negedge clk);
            chk("idle", {busy, bo_oe_n, aoe_n}, 3'h3);
        end
        $display("test tenure done");
        finish_test();
    end
endmodule
`default_nettype wire
